// ---- multi_io_flash_read_engine.sv ----
// Read-command engine of a multi-I/O serial NOR flash, with its read FIFO
// Summary of operation
// R1 - Dual read: address and mode byte arrive two bits per rising clock.
// R2 - Dual read returns data two bits per clock on lines 0 and 1.
// R3 - Reads start anywhere; address advances by one per output byte.
// R4 - Dual mode bits 5:4 equal 10: next frame skips the opcode.
// R5 - Other mode bits leave continuous mode; next frame needs an opcode.
// R6 - A continuous-mode reset command clears the mode bits.
// R7 - Quad read: address, mode, four dummy clocks, then quad data.
// R8 - Quad reads work only while the quad enable bit is set; checked at the opcode only, so continuous-mode frames skip it.
// R9 - Quad read with mode bits 10: next frame starts at the address.
// R10 - Word read: even address, two dummy clocks after the mode byte.
// R11 - Word read with mode bits 10: next frame is another word read.
// R12 - Wrap command: opcode, 24 dummy bits, wrap byte, chip select high.
// R13 - Stored wrap setting governs all later quad and word reads.
// R14 - Wrap disable bit: 0 enables, 1 disables; it powers up as 1.
// R15 - Wrap length field 00,01,10,11 gives 8,16,32,64-byte sections.
// R16 - Wrapped reads return to the aligned section start until deselect.
// R17 - Host leaves wrapping by writing the wrap disable bit as one.
// R18 - ID read at address zero returns maker code then device code.
// R19 - ID read at address one returns device code first.
// R20 - Output bits change on falling clock; inputs sampled on rising.
// R21 - Continuous flag resets clear, set only by read mode bytes.
// R22 - Chip select high ends the frame and stops output at once.

module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic flush,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r, rp_r;
	logic [AW:0] cnt_r, cnt_nxt;
	logic in_ready_r;
	wire push = in_valid && in_ready_r;
	wire take = out_valid && out_ready;

	// Ready is registered so that back-pressure leaves on a clean flop
	assign in_ready = in_ready_r;
	assign out_valid = cnt_r != '0;
	assign out_data = mem_r[rp_r];
	assign cnt_nxt = flush ? '0 : cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, take};

	// Storage needs no reset, only pointers, fill level and ready do
	always_ff @(posedge clk) begin
		if (push) mem_r[wp_r] <= in_data;
	end
	// Pointers, fill level and ready
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			in_ready_r <= 1'b0;
		end else begin
			wp_r <= flush ? '0 : wp_r + AW'(push);
			rp_r <= flush ? '0 : rp_r + AW'(take);
			cnt_r <= cnt_nxt;
			in_ready_r <= cnt_nxt != (AW+1)'(DEPTH);
		end
	end
endmodule : byte_fifo

module multi_io_flash_read_engine import flash_read_pkg::*; #(
	parameter logic [7:0] MANUF_CODE = 8'h5a, // Arbitrary value
	parameter logic [7:0] DEVICE_CODE = 8'h3c // Arbitrary value
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe,
	input wire logic quad_io_enable_bit,
	output logic mem_rd_en,
	output logic [23:0] mem_rd_addr,
	input wire logic [7:0] mem_rdata,
	input wire logic mem_rdata_valid,
	output logic mem_rdata_ready,
	output logic sticky_read_active,
	output logic [2:0] wrap_setting_bits
);
	// ****************************************
	// State
	// ****************************************
	phase_type state_r, state_nxt;
	logic sclk_r, cont_r, fetch_r, wrap_on_r, id_first_r, id_idx_r, mem_rd_en_r;
	logic [4:0] lanes_r, bit_cnt_r, dummy_bits_r;
	logic [23:0] sh_r, req_addr_r, mem_rd_addr_r;
	logic [7:0] op_r, out_byte_r;
	logic [3:0] obits_r, inflight_r, io_out_r, io_oe_r;
	logic [2:0] wrap_r;
	logic fifo_valid;
	logic [7:0] fifo_data;

	// ****************************************
	// Decode
	// ****************************************
	function automatic logic [4:0] lanes_for(input logic [7:0] op);
		lanes_for = (op == OP_DUAL_IO_READ) ? DUAL_LANES :
			(op == OP_QUAD_IO_READ || op == OP_QUAD_WORD_READ) ? QUAD_LANES : SINGLE_LANE;
	endfunction : lanes_for

	// Top lanes of a byte onto the pins; single-lane answers use line 1
	function automatic logic [3:0] lanes_out(input logic [7:0] b, input logic [4:0] l);
		lanes_out = (l == QUAD_LANES) ? b[7:4] :
			(l == DUAL_LANES) ? {2'h0, b[7:6]} : {2'h0, b[7], 1'b0};
	endfunction : lanes_out

	// Edges of the serial clock, only while selected
	wire sclk_rise = sclk && !sclk_r && !cs_n; // R1
	wire sclk_fall = !sclk && sclk_r && !cs_n; // R20
	wire [23:0] sh_nxt = (lanes_r == QUAD_LANES) ? {sh_r[19:0], io_in} :
		(lanes_r == DUAL_LANES) ? {sh_r[21:0], io_in[1:0]} : {sh_r[22:0], io_in[0]};
	wire [4:0] target = (state_r == st_addr) ? ADDR_BITS :
		(state_r == st_dummy) ? dummy_bits_r : MODE_BITS;
	wire phase_end = sclk_rise && (bit_cnt_r + lanes_r == target);
	wire [7:0] opcode_in = sh_nxt[7:0];
	wire quad_in = opcode_in == OP_QUAD_IO_READ || opcode_in == OP_QUAD_WORD_READ;
	wire op_known = opcode_in == OP_DUAL_IO_READ || (quad_in && quad_io_enable_bit) ||
		opcode_in == OP_SET_WRAP || opcode_in == OP_READ_ID; // R8
	wire op_quad = op_r == OP_QUAD_IO_READ || op_r == OP_QUAD_WORD_READ;
	wire op_read = op_quad || op_r == OP_DUAL_IO_READ;
	wire op_end = state_r == st_opcode && phase_end;
	wire addr_end = state_r == st_addr && phase_end;
	wire mode_end = state_r == st_mode && phase_end;
	wire mode_end_rd = mode_end && op_read;
	wire frame_open = state_r == st_idle && !cs_n;

	// Wrapped address stays inside an aligned section of a page
	wire [23:0] wrap_mask = (WRAP_BASE_LEN << wrap_r[2:1]) - 24'h000001; // R15
	wire [23:0] addr_inc = req_addr_r + 24'h000001; // R3
	wire [23:0] addr_next = wrap_on_r ?
		((req_addr_r & ~wrap_mask) | (addr_inc & wrap_mask)) : addr_inc; // R16

	// Output side: a byte is loaded when the previous one is spent
	wire load = sclk_fall && state_r == st_data && obits_r == 4'h0;
	wire [7:0] id_byte = (id_idx_r ^ id_first_r) ? DEVICE_CODE : MANUF_CODE; // R18 R19
	wire is_id = op_r == OP_READ_ID;
	wire [7:0] src_byte = is_id ? id_byte : fifo_data;
	wire pop = load && !is_id && fifo_valid;
	wire req = fetch_r && inflight_r < 4'(FIFO_DEPTH);

	assign io_out = io_out_r;
	assign io_oe = io_oe_r;
	assign mem_rd_en = mem_rd_en_r;
	assign mem_rd_addr = mem_rd_addr_r;
	assign sticky_read_active = cont_r;
	assign wrap_setting_bits = wrap_r;

	// ****************************************
	// Frame sequencer
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			st_idle: if (!cs_n) state_nxt = cont_r ? st_addr : st_opcode; // R4 R9 R11
			st_opcode: if (phase_end) state_nxt = op_known ? st_addr : st_ignore;
			st_addr: if (phase_end) state_nxt = is_id ? st_data : st_mode;
			st_mode: if (phase_end) state_nxt = (op_r == OP_SET_WRAP) ? st_ignore :
				(op_r == OP_DUAL_IO_READ) ? st_data : st_dummy;
			st_dummy: if (phase_end) state_nxt = st_data;
			st_data, st_ignore: state_nxt = state_r;
			default: state_nxt = st_idle;
		endcase
		if (cs_n) state_nxt = st_idle; // R22
	end

	// Phase, lane width and shifting of received bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= st_idle;
			sclk_r <= 1'b0;
			lanes_r <= SINGLE_LANE;
			bit_cnt_r <= 5'h00;
			sh_r <= 24'h000000;
		end else begin
			state_r <= state_nxt;
			sclk_r <= sclk;
			if (frame_open) lanes_r <= cont_r ? lanes_for(op_r) : SINGLE_LANE;
			else if (op_end) lanes_r <= lanes_for(opcode_in); // R1 R7
			bit_cnt_r <= (cs_n || phase_end) ? 5'h00 : bit_cnt_r + (sclk_rise ? lanes_r : 5'h00);
			if (sclk_rise) sh_r <= sh_nxt;
		end
	end

	// Command, dummy length, continuous flag and wrap setting
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			op_r <= 8'h00;
			dummy_bits_r <= 5'h00;
			cont_r <= 1'b0; // R21
			wrap_r <= WRAP_RESET; // R14
		end else begin
			if (op_end) op_r <= opcode_in;
			if (mode_end) dummy_bits_r <= (op_r == OP_QUAD_WORD_READ) ?
				5'(WORD_DUMMY_CLKS * 4) : 5'(QUAD_DUMMY_CLKS * 4); // R7 R10
			if (mode_end_rd) begin
				cont_r <= sh_nxt[SEL_LO+:2] == STICKY_KEEP; // R4 R5 R9 R11
			end else if ((op_end && opcode_in == OP_CRM_RESET) ||
					(cs_n && state_r == st_addr && cont_r)) begin
				cont_r <= 1'b0; // R6
			end
			if (mode_end && op_r == OP_SET_WRAP) wrap_r <= sh_nxt[WRAP_LO+:3]; // R13 R17
		end
	end

	// ****************************************
	// Memory fetch ahead of the serial output
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fetch_r <= 1'b0;
			wrap_on_r <= 1'b0;
			id_first_r <= 1'b0;
			req_addr_r <= 24'h000000;
			mem_rd_en_r <= 1'b0;
			mem_rd_addr_r <= 24'h000000;
			inflight_r <= 4'h0;
		end else begin
			if (cs_n) fetch_r <= 1'b0; // R22
			else if (addr_end) begin
				fetch_r <= op_read;
				wrap_on_r <= op_quad && !wrap_r[0]; // R13 R14
				id_first_r <= sh_nxt[0];
				req_addr_r <= sh_nxt;
			end else if (req) begin
				req_addr_r <= addr_next; // R3 R16
			end
			mem_rd_en_r <= req && !cs_n;
			if (req) mem_rd_addr_r <= req_addr_r;
			// Credits keep every answer a slot in the FIFO
			inflight_r <= cs_n ? 4'h0 : inflight_r + {3'h0, req} - {3'h0, pop};
		end
	end

	// Answers arriving after deselect are dropped, never replayed
	byte_fifo #(
		.WIDTH(BYTE_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.flush(cs_n),
		.in_valid(mem_rdata_valid && fetch_r),
		.in_data(mem_rdata),
		.in_ready(mem_rdata_ready),
		.out_valid(fifo_valid),
		.out_data(fifo_data),
		.out_ready(pop)
	);

	// ****************************************
	// Serial output, driven on falling edges
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_byte_r <= 8'h00;
			obits_r <= 4'h0;
			io_out_r <= 4'h0;
			io_oe_r <= 4'h0;
			id_idx_r <= 1'b0;
		end else if (cs_n) begin
			obits_r <= 4'h0; // R22
			io_out_r <= 4'h0;
			io_oe_r <= 4'h0;
			id_idx_r <= 1'b0;
		end else if (sclk_fall && state_r == st_data) begin
			io_oe_r <= (lanes_r == QUAD_LANES) ? OE_QUAD :
				(lanes_r == DUAL_LANES) ? OE_DUAL : OE_SINGLE; // R2 R7
			if (load) begin
				out_byte_r <= src_byte << lanes_r;
				obits_r <= 4'h8 - lanes_r[3:0];
				io_out_r <= lanes_out(src_byte, lanes_r); // R20
				id_idx_r <= !id_idx_r;
			end else begin
				out_byte_r <= out_byte_r << lanes_r;
				obits_r <= obits_r - lanes_r[3:0];
				io_out_r <= lanes_out(out_byte_r, lanes_r); // R20
			end
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// One check per guarded rule, kept terse so the file stays compact
	property p_drive_on_fall;
		!cs_n && !$past(cs_n) && io_out_r != $past(io_out_r) |-> $past(sclk_fall); endproperty
	a_drive_on_fall: assert property (p_drive_on_fall) else $error("pins moved off a fall"); // R20
	property p_release; cs_n |=> io_oe_r == 4'h0 && state_r == st_idle; endproperty
	a_release: assert property (p_release) else $error("pins driven after deselect"); // R22
	property p_qe_gate;
		op_end && quad_in && !quad_io_enable_bit |=> state_r != st_addr; endproperty
	a_qe_gate: assert property (p_qe_gate) else $error("quad read taken while disabled"); // R8
	property p_keep; mode_end_rd && sh_nxt[SEL_LO+:2] == STICKY_KEEP |=> cont_r; endproperty
	a_keep: assert property (p_keep) else $error("continuous read not entered"); // R4
	property p_leave; mode_end_rd && sh_nxt[SEL_LO+:2] != STICKY_KEEP |=> !cont_r; endproperty
	a_leave: assert property (p_leave) else $error("continuous read not left"); // R5
	property p_cont_src; $rose(cont_r) |-> $past(state_r) == st_mode; endproperty
	a_cont_src: assert property (p_cont_src) else $error("flag set outside a mode byte"); // R21
	property p_skip_opcode; frame_open && cont_r |=> state_r != st_opcode; endproperty
	a_skip_opcode: assert property (p_skip_opcode) else $error("frame waited for opcode"); // R9
	property p_linear;
		mem_rd_en_r && $past(mem_rd_en_r) && !wrap_on_r |->
			mem_rd_addr_r == $past(mem_rd_addr_r) + 24'h000001; endproperty
	a_linear: assert property (p_linear) else $error("linear address not advanced"); // R3
	property p_wrap_stay;
		mem_rd_en_r && $past(mem_rd_en_r) && wrap_on_r |->
			mem_rd_addr_r[23:6] == $past(mem_rd_addr_r[23:6]); endproperty
	a_wrap_stay: assert property (p_wrap_stay) else $error("wrapped read left section"); // R16
	property p_dual_lanes;
		state_r == st_data && op_r == OP_DUAL_IO_READ && io_oe_r != 4'h0 |-> io_oe_r == OE_DUAL;
	endproperty
	a_dual_lanes: assert property (p_dual_lanes) else $error("dual read wrong lanes"); // R2
	property p_wrap_write;
		wrap_r != $past(wrap_r) |-> $past(mode_end && op_r == OP_SET_WRAP); endproperty
	a_wrap_write: assert property (p_wrap_write) else $error("wrap changed without command"); // R13
	c_dual_data: cover property (pop && op_r == OP_DUAL_IO_READ);
	c_cont_frame: cover property (frame_open && cont_r);
	c_wrap_req: cover property (req && wrap_on_r && addr_next[5:0] == 6'h00);
	c_id_out: cover property (load && is_id && id_first_r);
endmodule : multi_io_flash_read_engine

// ---- flash_read_pkg.sv ----
// Constants and types shared by the multi-I/O flash read engine
package flash_read_pkg;

	// ****************************************
	// Instruction codes
	// ****************************************
	localparam logic [7:0] OP_DUAL_IO_READ = 8'hbb;
	localparam logic [7:0] OP_QUAD_IO_READ = 8'heb;
	localparam logic [7:0] OP_QUAD_WORD_READ = 8'he7;
	localparam logic [7:0] OP_SET_WRAP = 8'h77;
	localparam logic [7:0] OP_READ_ID = 8'h90;
	localparam logic [7:0] OP_CRM_RESET = 8'hff;

	// ****************************************
	// Frame layout: field bits, dummy clocks and lane counts
	// ****************************************
	localparam logic [4:0] ADDR_BITS = 5'h18;
	localparam logic [4:0] MODE_BITS = 5'h08;
	localparam int QUAD_DUMMY_CLKS = 4;
	localparam int WORD_DUMMY_CLKS = 2;
	localparam logic [4:0] QUAD_LANES = 5'h04;
	localparam logic [4:0] DUAL_LANES = 5'h02;
	localparam logic [4:0] SINGLE_LANE = 5'h01;

	// ****************************************
	// Mode byte and wrap byte fields
	// ****************************************
	localparam int SEL_LO = 4;
	localparam logic [1:0] STICKY_KEEP = 2'h2;
	localparam int WRAP_LO = 4;
	localparam logic [2:0] WRAP_RESET = 3'h1;
	localparam logic [23:0] WRAP_BASE_LEN = 24'h000008;

	// ****************************************
	// Output enables per lane count and buffering
	// ****************************************
	localparam logic [3:0] OE_SINGLE = 4'h2;
	localparam logic [3:0] OE_DUAL = 4'h3;
	localparam logic [3:0] OE_QUAD = 4'hf;
	localparam int FIFO_DEPTH = 8;
	localparam int BYTE_W = 8;

	typedef enum logic [6:0] {
		st_idle = 7'h01,
		st_opcode = 7'h02,
		st_addr = 7'h04,
		st_mode = 7'h08,
		st_dummy = 7'h10,
		st_data = 7'h20,
		st_ignore = 7'h40
	} phase_type;

endpackage : flash_read_pkg

// ---- spi_host_model.sv ----
// Host controller model that frames commands and clocks the serial link
module spi_host_model (
	input wire logic clk,
	output logic cs_n,
	output logic sclk,
	output logic [3:0] io_in,
	input wire logic [3:0] io_out,
	input wire logic [3:0] io_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// Line levels and framing
	// ****************************************
	localparam int HALF = 4;
	logic [3:0] drv_v = 4'h0;
	logic [3:0] drv_e = 4'h0;
	logic [3:0] last_v = 4'h0;
	wire logic [3:0] line_v;
	// No pulls on these lines, so an undriven line toggles rather than hold a value
	assign line_v = (drv_e & drv_v) | (~drv_e & io_oe & io_out) | (~drv_e & ~io_oe & ~last_v);
	assign io_in = line_v;
	always @(posedge clk) begin
		last_v <= line_v;
	end
	// Clock stands low and chip select high outside frames
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
	end
	task automatic start();
		@(posedge clk);
		cs_n <= 1'b0;
		repeat (HALF) @(posedge clk);
	endtask : start
	// Send or receive n bits over l lanes, MSB first, highest lane carrying the higher bit
	task automatic clocks(input logic [63:0] v, input int n, input int l, input bit drv,
		output logic [63:0] r);
		logic [63:0] s;
		logic [3:0] m;
		s = v << (64 - n);
		m = (l == 1) ? 4'h1 : (l == 2) ? 4'h3 : 4'hf;
		r = 64'h0;
		for (int k = 0; k < n; k += l) begin
			sclk <= 1'b0;
			drv_v <= s[63:60] >> (4 - l);
			drv_e <= drv ? m : 4'h0;
			s = s << l;
			repeat (HALF) @(posedge clk);
			sclk <= 1'b1;
			r = (r << l) | ((l == 1) ? {63'h0, line_v[1]} : {60'h0, line_v & m});
			repeat (HALF) @(posedge clk);
		end
	endtask : clocks
	task automatic stop();
		sclk <= 1'b0;
		drv_e <= 4'h0;
		repeat (HALF) @(posedge clk);
		cs_n <= 1'b1;
		repeat (HALF) @(posedge clk);
	endtask : stop
endmodule : spi_host_model

// ---- test_multi_io_flash_read_engine.sv ----
// Self-checking bench of the multi-I/O flash read engine
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin error_cnt++; \
	$display("ERROR %s expected %h seen %h", nm, exp, got); end end
module test_multi_io_flash_read_engine import flash_read_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// Design, host and array model
	// ****************************************
	localparam logic [7:0] man_code = 8'h5a; // Arbitrary value
	localparam logic [7:0] dev_code = 8'h3c; // Arbitrary value
	localparam int limit = 40000;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic qe = 1'b1;
	logic cs_n, sclk, mem_rd_en, mem_rdata_ready, sticky_read_active;
	logic [3:0] io_in, io_out, io_oe;
	logic [23:0] mem_rd_addr;
	logic [7:0] mem_rdata = 8'h00;
	logic mem_rdata_valid = 1'b0;
	logic [2:0] wrap_setting_bits;
	logic [23:0] pend[$];
	int error_cnt = 0;
	int n_checks = 0;
	int cyc_cnt = 0;
	always #10 clk = ~clk;
	multi_io_flash_read_engine #(.MANUF_CODE(man_code), .DEVICE_CODE(dev_code)) dut_u (
		.clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .io_in(io_in), .io_out(io_out),
		.io_oe(io_oe), .quad_io_enable_bit(qe), .mem_rd_en(mem_rd_en),
		.mem_rd_addr(mem_rd_addr), .mem_rdata(mem_rdata), .mem_rdata_valid(mem_rdata_valid),
		.mem_rdata_ready(mem_rdata_ready), .sticky_read_active(sticky_read_active),
		.wrap_setting_bits(wrap_setting_bits));
	spi_host_model host_u (.clk(clk), .cs_n(cs_n), .sclk(sclk), .io_in(io_in),
		.io_out(io_out), .io_oe(io_oe));
	function automatic logic [7:0] mem_byte(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h96;
	endfunction : mem_byte
	// Array answers in order, one cycle late; a deselect drops what is still pending
	always @(posedge clk) begin
		if (cs_n) begin
			pend.delete();
		end else begin
			if (mem_rdata_valid && mem_rdata_ready) void'(pend.pop_front());
			if (mem_rd_en) pend.push_back(mem_rd_addr);
		end
		mem_rdata_valid <= (pend.size() != 0);
		mem_rdata <= (pend.size() != 0) ? mem_byte(pend[0]) : 8'h00;
	end
	// A hung handshake ends the run here instead of stalling forever
	always @(posedge clk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == limit) begin
			error_cnt++;
			$display("ERROR timeout expected %0d seen %0d", limit, cyc_cnt);
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	// ****************************************
	// Command tasks
	// ****************************************
	// One read frame; wl is the wrap section length or 0 for linear
	task automatic rd(input logic [7:0] op, input bit with_op, input logic [23:0] a, input int l,
		input logic [7:0] m, input int dmy, input int nb, input int wl, input bit pause);
		logic [63:0] r;
		logic [23:0] ea;
		logic [7:0] eb;
		host_u.start();
		if (with_op) host_u.clocks(64'(op), 8, 1, 1, r);
		host_u.clocks(64'(a), 24, l, 1, r);
		if (op != OP_READ_ID) host_u.clocks(64'(m), 8, l, 1, r);
		if (dmy > 0) host_u.clocks(64'h0, dmy * l, l, 0, r);
		for (int i = 0; i < nb; i++) begin
			host_u.clocks(64'h0, 8, l, 0, r);
			ea = a + 24'(i);
			if (wl != 0) ea = (a & ~24'(wl - 1)) | (ea & 24'(wl - 1));
			eb = (op == OP_READ_ID) ? ((a[0] ^ i[0]) ? dev_code : man_code) : mem_byte(ea);
			`CHK("read_byte", eb, r[7:0])
			if (i == 0) `CHK("io_oe", (l == 4) ? OE_QUAD : (l == 2) ? OE_DUAL : OE_SINGLE, io_oe)
			if (pause && i == 0) begin
				repeat (60) @(posedge clk);
				`CHK("mem_rdata_ready", 1'b0, mem_rdata_ready)
			end
		end
		host_u.stop();
		repeat (2) @(posedge clk);
		`CHK("io_oe_idle", 4'h0, io_oe)
	endtask : rd
	task automatic cmd_only(input logic [7:0] op, input logic [7:0] wb, input bit has_wb);
		logic [63:0] r;
		host_u.start();
		host_u.clocks(64'(op), 8, 1, 1, r);
		if (has_wb) host_u.clocks(64'h0, 24, 1, 1, r);
		if (has_wb) host_u.clocks(64'(wb), 8, 1, 1, r);
		host_u.stop();
	endtask : cmd_only
	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		logic [63:0] r;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK("wrap_setting_bits", WRAP_RESET, wrap_setting_bits)
		`CHK("sticky_read_active", 1'b0, sticky_read_active)
		rd(OP_READ_ID, 1, 24'h000000, 1, 8'h00, 0, 4, 0, 0);
		rd(OP_READ_ID, 1, 24'h000001, 1, 8'h00, 0, 2, 0, 0);
		rd(OP_DUAL_IO_READ, 1, 24'h0001fe, 2, 8'h20, 0, 4, 0, 0);
		`CHK("sticky_read_active", 1'b1, sticky_read_active)
		rd(OP_DUAL_IO_READ, 0, 24'h000310, 2, 8'h20, 0, 12, 0, 1);
		rd(OP_DUAL_IO_READ, 0, 24'h000400, 2, 8'h00, 0, 2, 0, 0);
		`CHK("sticky_read_active", 1'b0, sticky_read_active)
		rd(OP_DUAL_IO_READ, 1, 24'h000020, 2, 8'h00, 0, 1, 0, 0);
		// Quad opcode with the enable bit clear must leave the pins undriven
		qe <= 1'b0;
		host_u.start();
		host_u.clocks(64'(OP_QUAD_IO_READ), 8, 1, 1, r);
		host_u.clocks(64'h123456, 24, 4, 1, r);
		host_u.clocks(64'h0, 32, 4, 0, r);
		`CHK("io_oe_refused", 4'h0, io_oe)
		host_u.stop();
		qe <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			cmd_only(OP_SET_WRAP, {1'b0, c[1:0], 5'h00}, 1);
			`CHK("wrap_setting_bits", {c[1:0], 1'b0}, wrap_setting_bits)
			rd(OP_QUAD_IO_READ, 1, 24'h000123, 4, 8'h00, 4, (8 << c) + 2, 8 << c, 0);
		end
		rd(OP_QUAD_WORD_READ, 1, 24'h0001f6, 4, 8'h20, 2, 12, 64, 0);
		`CHK("sticky_read_active", 1'b1, sticky_read_active)
		rd(OP_QUAD_WORD_READ, 0, 24'h000500, 4, 8'h00, 2, 2, 64, 0);
		cmd_only(OP_SET_WRAP, 8'h10, 1);
		`CHK("wrap_setting_bits", 3'h1, wrap_setting_bits)
		rd(OP_QUAD_IO_READ, 1, 24'h0002fe, 4, 8'h20, 4, 4, 0, 0);
		rd(OP_QUAD_IO_READ, 0, 24'h000600, 4, 8'h20, 4, 2, 0, 0);
		cmd_only(OP_CRM_RESET, 8'h00, 0);
		`CHK("sticky_read_active", 1'b0, sticky_read_active)
		rd(OP_DUAL_IO_READ, 1, 24'h000777, 2, 8'h00, 0, 2, 0, 0);
		complete_run();
	end
endmodule : test_multi_io_flash_read_engine
